// >>> rtl/flash_cmd_cfg.svh
// Constants for the parallel flash command-sequence host controller
`ifndef FLASH_CMD_CFG_SVH
`define FLASH_CMD_CFG_SVH

// ----------------------------------------------------------------
// Command addresses and data
// ----------------------------------------------------------------
`define UNLOCK_ADDR1 20'h0_0555
`define UNLOCK_ADDR2 20'h0_02AA
`define UNLOCK_DATA1 8'hAA
`define UNLOCK_DATA2 8'h55
`define CMD_PROGRAM 8'hA0
`define CMD_ERASE_SETUP 8'h80
`define CMD_SECTOR_ERASE 8'h30
`define CMD_BLOCK_ERASE 8'h50
`define CMD_CHIP_ERASE 8'h10
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30
`define CMD_SECID_QUERY 8'h88
`define CMD_SECID_PROGRAM 8'hA5
`define CMD_SECID_LOCK 8'h85
`define CMD_SWID_ENTRY 8'h90
`define CMD_CFI_ENTRY 8'h98
`define CMD_EXIT 8'hF0
`define SECID_LOCK_DATA 16'h0000

// ----------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------
`define BANK_HI 19
`define BANK_LO 18
`define SECTOR_LO 11
`define BLOCK_LO 15
`define SECID_BOTTOM_BASE 20'h0_0000
`define SECID_TOP_BASE 20'hC_0000
`define SECID_USER_OFS 20'h0_0010
`define SECID_LOCK_OFS 20'h0_00FF
`define LOCK_STATE_BIT 3

// ----------------------------------------------------------------
// Bus timing, in ns and cycles at 100 MHz
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define WE_LOW_NS 40
`define WE_HIGH_NS 30
`define RD_ACCESS_NS 70
`define WE_LOW_CYC ((`WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_HIGH_CYC ((`WE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_ACCESS_CYC ((`RD_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 2)

`endif

// >>> rtl/flash_cmd_pkg.sv
// Types shared by the flash command host controller
package flash_cmd_pkg;

  // Host command codes
  typedef enum logic [3:0] {
    OP_PROGRAM = 4'h0,
    OP_SECTOR_ERASE = 4'h1,
    OP_BLOCK_ERASE = 4'h2,
    OP_CHIP_ERASE = 4'h3,
    OP_SUSPEND = 4'h4,
    OP_RESUME = 4'h5,
    OP_SECID_QUERY = 4'h6,
    OP_SECID_PROGRAM = 4'h7,
    OP_SECID_LOCK = 4'h8,
    OP_SWID_ENTRY = 4'h9,
    OP_CFI_ENTRY = 4'hA,
    OP_EXIT_LONG = 4'hB,
    OP_EXIT_SHORT = 4'hC,
    OP_READ = 4'hD,
    OP_ABORT = 4'hE
  } op_e;

  // One host request
  typedef struct packed {
    op_e op;
    logic [19:0] addr;
    logic [15:0] data;
  } req_s;

  // One bus write cycle
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
  } cycle_s;

endpackage

// >>> rtl/seq_rom.sv
// Lookup of the write cycles that make up each command sequence
module seq_rom
  import flash_cmd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Lookup
  input wire op_e op,
  input wire logic [2:0] step,
  input wire logic [19:0] req_addr,
  input wire logic [15:0] req_data,
  // Registered result
  output cycle_s cycle_q,
  output logic last_q
);
`include "flash_cmd_cfg.svh"

  // ----------------------------------------------------------------
  // Combinational table
  // ----------------------------------------------------------------
  cycle_s cyc_d; // Next cycle contents
  logic last_d; // Step is the final write
  logic [2:0] nwr; // Writes in this sequence
  logic [19:0] bank_base; // Bank bits with zeros below

  // Cycle selection by command and step
  always_comb begin
    bank_base = '0;
    bank_base[`BANK_HI:`BANK_LO] = req_addr[`BANK_HI:`BANK_LO];
    cyc_d = '{addr: `UNLOCK_ADDR1, data: {8'h00, `UNLOCK_DATA1}};
    nwr = 3'd3;
    case (op)
      OP_PROGRAM, OP_SECID_PROGRAM, OP_SECID_LOCK: nwr = 3'd4;
      OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE: nwr = 3'd6;
      OP_SUSPEND, OP_RESUME, OP_EXIT_SHORT: nwr = 3'd1;
      default: nwr = 3'd3;
    endcase
    // Unlock pair opens every long sequence, again at 3 and 4 for erase
    if (step == 3'd1 || step == 3'd4) begin
      cyc_d = '{addr: `UNLOCK_ADDR2, data: {8'h00, `UNLOCK_DATA2}};
    end else if (step == 3'd3) begin
      cyc_d = '{addr: `UNLOCK_ADDR1, data: {8'h00, `UNLOCK_DATA1}};
    end
    case (op)
      OP_PROGRAM: begin
        if (step == 3'd2) cyc_d.data = {8'h00, `CMD_PROGRAM};
        if (step == 3'd3) cyc_d = '{addr: req_addr, data: req_data};
      end
      OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE: begin
        if (step == 3'd2) cyc_d.data = {8'h00, `CMD_ERASE_SETUP};
        if (step == 3'd5 && op == OP_SECTOR_ERASE) begin
          cyc_d = '{addr: {req_addr[19:`SECTOR_LO], 11'h000},
                    data: {8'h00, `CMD_SECTOR_ERASE}};
        end
        if (step == 3'd5 && op == OP_BLOCK_ERASE) begin
          cyc_d = '{addr: {req_addr[19:`BLOCK_LO], 15'h0000},
                    data: {8'h00, `CMD_BLOCK_ERASE}};
        end
        if (step == 3'd5 && op == OP_CHIP_ERASE) begin
          cyc_d = '{addr: `UNLOCK_ADDR1, data: {8'h00, `CMD_CHIP_ERASE}};
        end
      end
      OP_SUSPEND: cyc_d = '{addr: req_addr, data: {8'h00, `CMD_SUSPEND}};
      OP_RESUME: cyc_d = '{addr: req_addr, data: {8'h00, `CMD_RESUME}};
      OP_EXIT_SHORT: cyc_d = '{addr: req_addr, data: {8'h00, `CMD_EXIT}};
      OP_SECID_QUERY: begin
        if (step == 3'd2) cyc_d.data = {8'h00, `CMD_SECID_QUERY};
      end
      OP_SECID_PROGRAM: begin
        if (step == 3'd2) cyc_d.data = {8'h00, `CMD_SECID_PROGRAM};
        if (step == 3'd3) cyc_d = '{addr: req_addr, data: req_data};
      end
      OP_SECID_LOCK: begin
        if (step == 3'd2) cyc_d.data = {8'h00, `CMD_SECID_LOCK};
        if (step == 3'd3) cyc_d = '{addr: req_addr, data: `SECID_LOCK_DATA};
      end
      OP_SWID_ENTRY: begin
        if (step == 3'd2) begin
          cyc_d = '{addr: bank_base | `UNLOCK_ADDR1,
                    data: {8'h00, `CMD_SWID_ENTRY}};
        end
      end
      OP_CFI_ENTRY: begin
        if (step == 3'd2) begin
          cyc_d = '{addr: bank_base | `UNLOCK_ADDR1,
                    data: {8'h00, `CMD_CFI_ENTRY}};
        end
      end
      OP_EXIT_LONG: begin
        if (step == 3'd2) cyc_d.data = {8'h00, `CMD_EXIT};
      end
      default: cyc_d = '{addr: req_addr, data: req_data};
    endcase
    last_d = (step == nwr - 3'd1);
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  // Registered so the pins see stable values from the edge on which the strobe falls
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cycle_q <= '0;
      last_q <= 1'b0;
    end else begin
      cycle_q <= cyc_d;
      last_q <= last_d;
    end
  end

endmodule // seq_rom

// >>> rtl/flash_cmd_host.sv
// Host controller that drives command sequences onto a parallel flash
module flash_cmd_host
  import flash_cmd_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request port
  input wire logic req_valid,
  output logic req_ready,
  input wire req_s req,
  // Answer port
  output logic done_q,
  output logic refused_q,
  output logic [DATA_W-1:0] rdata_q,
  // Mode strap
  input wire logic word_mode,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr_q,
  input wire logic [DATA_W-1:0] flash_dq_i,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  output logic flash_ce_n_q,
  output logic flash_oe_n_q,
  output logic flash_we_n_q,
  output logic flash_rst_n_q,
  output logic flash_byte_n_q
);
`include "flash_cmd_cfg.svh"

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_WE_LOW = 3'b010,
    ST_WE_HIGH = 3'b011,
    ST_READ = 3'b100,
    ST_RESET = 3'b101
  } state_e;

  localparam logic [3:0] WE_LOW_CYC = 4'(`WE_LOW_CYC); // Strobe low time
  localparam logic [3:0] WE_HIGH_CYC = 4'(`WE_HIGH_CYC); // Strobe recovery
  localparam logic [3:0] RD_CYC = 4'(`RD_ACCESS_CYC); // Read access plus sync

  state_e state_q; // Bus sequencer state
  req_s cur_q; // Accepted request
  logic [2:0] step_q; // Write cycle index
  logic [3:0] cnt_q; // Phase timer
  logic [DATA_W-1:0] dq_s1_q; // Data pin sync stage one
  logic [DATA_W-1:0] dq_s2_q; // Data pin sync stage two
  cycle_s cycle; // Current write cycle
  logic last; // Current write is the final
  logic bad_req; // Request breaks a pin constraint

  // Cycle table, registered
  seq_rom u_seq_rom (
    .clk(clk),
    .rstn(rstn),
    .op(cur_q.op),
    .step(step_q),
    .req_addr(cur_q.addr),
    .req_data(cur_q.data),
    .cycle_q(cycle),
    .last_q(last)
  );

  // ----------------------------------------------------------------
  // Request handshake
  // ----------------------------------------------------------------
  // Ready only in idle; one request runs to completion
  assign req_ready = (state_q == ST_IDLE);
  // Lock-out in byte mode is refused rather than sent
  assign bad_req = (req.op == OP_SECID_LOCK) && !word_mode;

  // ----------------------------------------------------------------
  // Data pin synchroniser
  // ----------------------------------------------------------------
  // Flash data is asynchronous to clk, so two flops before use
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Every sequence is emitted whole; a partial one would leave the
  // device decoder mid-sequence until a mismatch drops it back
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      step_q <= '0;
      cnt_q <= '0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          step_q <= '0;
          if (req_valid) begin
            cur_q <= req;
            if (bad_req) begin
              refused_q <= 1'b1;
            end else if (req.op == OP_READ) begin
              state_q <= ST_READ;
            end else if (req.op == OP_ABORT) begin
              state_q <= ST_RESET;
            end else begin
              state_q <= ST_SETUP;
            end
          end
        end
        // Table output settles one cycle after step changes
        ST_SETUP: begin
          state_q <= ST_WE_LOW;
          cnt_q <= '0;
        end
        ST_WE_LOW: begin
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == WE_LOW_CYC - 4'd1) begin
            state_q <= ST_WE_HIGH;
            cnt_q <= '0;
          end
        end
        ST_WE_HIGH: begin
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == WE_HIGH_CYC - 4'd1) begin
            cnt_q <= '0;
            if (last) begin
              state_q <= ST_IDLE;
              done_q <= 1'b1;
            end else begin
              step_q <= step_q + 3'd1;
              state_q <= ST_SETUP;
            end
          end
        end
        // Array or ID/status read; address supplies the map location
        ST_READ: begin
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == RD_CYC - 4'd1) begin
            rdata_q <= dq_s2_q;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        // Reset pulse on the flash reset pin
        ST_RESET: begin
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == RD_CYC - 4'd1) begin
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // All strobes registered to avoid glitches on the flash pins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      flash_addr_q <= '0;
      flash_dq_o <= '0;
      flash_dq_oe <= 1'b0;
      flash_ce_n_q <= 1'b1;
      flash_oe_n_q <= 1'b1;
      flash_we_n_q <= 1'b1;
      flash_rst_n_q <= 1'b0;
      flash_byte_n_q <= 1'b1;
    end else begin
      flash_byte_n_q <= word_mode;
      flash_rst_n_q <= (state_q != ST_RESET);
      flash_we_n_q <= !(state_q == ST_WE_LOW);
      flash_ce_n_q <= !(state_q inside {ST_SETUP, ST_WE_LOW, ST_WE_HIGH, ST_READ});
      flash_oe_n_q <= !(state_q == ST_READ);
      flash_dq_oe <= (state_q inside {ST_SETUP, ST_WE_LOW, ST_WE_HIGH});
      if (state_q == ST_READ) begin
        flash_addr_q <= cur_q.addr;
      end else begin
        // Upper bits driven from table, never floating
        flash_addr_q <= cycle.addr;
      end
      flash_dq_o <= cycle.data;
      if (!word_mode) begin
        // Byte mode: top data pin is the extra low address bit
        flash_dq_o[DATA_W-1] <= 1'b0;
      end
    end
  end

endmodule // flash_cmd_host

// >>> tb/flash_cmd_host_checker.sv
// Port-level assertions for the flash command host
module flash_cmd_host_checker
  import flash_cmd_pkg::*;
(
  // Clock, reset and request side
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire req_s req,
  input wire logic done_q,
  input wire logic refused_q,
  input wire logic word_mode,
  // Flash pins
  input wire logic [19:0] flash_addr_q,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n_q,
  input wire logic flash_oe_n_q,
  input wire logic flash_we_n_q,
  input wire logic flash_rst_n_q,
  input wire logic flash_byte_n_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Properties
  // ----
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_we_select: assert property (!flash_we_n_q |-> !flash_ce_n_q && flash_oe_n_q)
    else $error("write strobe without select");
  chk_we_width: assert property ($fell(flash_we_n_q) |-> !flash_we_n_q[*4] ##1 flash_we_n_q)
    else $error("write strobe width wrong");
  chk_data_hold: assert property (!flash_we_n_q ##1 !flash_we_n_q
    |-> $stable(flash_dq_o) && $stable(flash_addr_q) && flash_dq_oe)
    else $error("bus moved under strobe");
  chk_no_fight: assert property (flash_dq_oe |-> flash_oe_n_q)
    else $error("bus driven while device outputs");
  chk_byte_pin: assert property (rstn |=> flash_byte_n_q == $past(word_mode))
    else $error("byte pin does not follow mode");
  chk_lock_refused: assert property (req_valid && req_ready && req.op == OP_SECID_LOCK
    && !word_mode |=> refused_q)
    else $error("byte mode lock not refused");
  chk_refused_quiet: assert property (refused_q |-> flash_we_n_q[*3])
    else $error("refused lock still written");
  chk_done_pulse: assert property (done_q |=> !done_q)
    else $error("done longer than a cycle");
  chk_abort_pin: assert property (req_valid && req_ready && req.op == OP_ABORT
    |-> ##[1:3] !flash_rst_n_q)
    else $error("abort did not pulse reset pin");
endmodule // flash_cmd_host_checker

bind flash_cmd_host flash_cmd_host_checker u_chk (.clk, .rstn, .req_valid, .req_ready, .req,
  .done_q, .refused_q, .word_mode, .flash_addr_q, .flash_dq_o, .flash_dq_oe, .flash_ce_n_q,
  .flash_oe_n_q, .flash_we_n_q, .flash_rst_n_q, .flash_byte_n_q);

// >>> tb/flash_dev_model.sv
// Behavioural parallel flash that logs write cycles and answers reads
module flash_dev_model (
  // Sampling clock
  input wire logic clk,
  // Host pins
  input wire logic [19:0] addr,
  input wire logic [15:0] dq_in,
  input wire logic dq_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_n,
  output logic [15:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] got[$]; // Logged {addr, data} writes
  logic [35:0] cur_q; // Cycle latched while strobe low
  logic we_q; // Strobe one sample ago
  logic [15:0] idle_q; // Changing junk when not driving

  initial begin
    we_q = 1'b1;
    cur_q = '0;
    idle_q = 16'h0F0F;
  end

  // Released bus shows a toggling pattern so a stale value never passes
  assign dq_out = (!ce_n && !oe_n) ? (addr[15:0] ^ 16'h5A5A) : idle_q;

  // Log each completed write; reset pin clears the whole write log
  always @(posedge clk) begin
    we_q <= we_n;
    idle_q <= ~idle_q;
    if (!rst_n) begin
      got.delete();
    end else if (!we_n && !ce_n && dq_oe) begin
      cur_q <= {addr, dq_in};
    end else if (we_n && !we_q) begin
      got.push_back(cur_q);
    end
  end
endmodule // flash_dev_model

// >>> tb/flash_cmd_host_tb.sv
// Self-checking bench for the flash command host
module flash_cmd_host_tb
  import flash_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Signals
  // ----
  logic clk, rstn, req_valid, req_ready, done_q, refused_q, word_mode;
  req_s req;
  logic [15:0] rdata_q, flash_dq_i, flash_dq_o;
  logic [19:0] flash_addr_q;
  logic flash_dq_oe, ce_n, oe_n, we_n, frst_n, byte_n;
  int errors;
  int checks;
  logic [35:0] exp_q[$]; // Expected {addr, data} writes
  logic [35:0] msk_q[$]; // Bits that matter per write
  logic got_ref; // Refusal seen in last request
  logic low_rst; // Reset pin seen low in last request

  flash_cmd_host u_flash_cmd_host (.clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .done_q(done_q), .refused_q(refused_q),
    .rdata_q(rdata_q), .word_mode(word_mode), .flash_addr_q(flash_addr_q),
    .flash_dq_i(flash_dq_i), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n_q(ce_n), .flash_oe_n_q(oe_n), .flash_we_n_q(we_n), .flash_rst_n_q(frst_n),
    .flash_byte_n_q(byte_n));
  flash_dev_model u_flash_dev_model (.clk(clk), .addr(flash_addr_q), .dq_in(flash_dq_o),
    .dq_oe(flash_dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rst_n(frst_n),
    .dq_out(flash_dq_i));

  // ----
  // Helpers
  // ----
  task automatic test_done();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic put(input logic [19:0] a, input logic [15:0] d, input logic [19:0] am,
                     input logic [15:0] dm);
    exp_q.push_back({a, d});
    msk_q.push_back({am, dm});
  endtask

  // Command cycle: only A10..A0 and the low data byte count
  task automatic cmd(input logic [19:0] a, input logic [7:0] d);
    put(a, {8'h00, d}, 20'h0_07FF, 16'h00FF);
  endtask

  // Reference model of the write cycles each request must produce
  task automatic build(input op_e op, input logic [19:0] a, input logic [15:0] d);
    if (op == OP_SECID_LOCK && word_mode === 1'b0)
      return;
    if (op inside {[OP_PROGRAM:OP_CHIP_ERASE], [OP_SECID_QUERY:OP_EXIT_LONG]}) begin
      cmd(20'h0_0555, 8'hAA);
      cmd(20'h0_02AA, 8'h55);
    end
    if (op inside {[OP_SECTOR_ERASE:OP_CHIP_ERASE]}) begin
      cmd(20'h0_0555, 8'h80);
      cmd(20'h0_0555, 8'hAA);
      cmd(20'h0_02AA, 8'h55);
    end
    case (op)
      OP_PROGRAM: cmd(20'h0_0555, 8'hA0);
      OP_SECID_QUERY: cmd(20'h0_0555, 8'h88);
      OP_SECID_PROGRAM: cmd(20'h0_0555, 8'hA5);
      OP_SECID_LOCK: cmd(20'h0_0555, 8'h85);
      OP_EXIT_LONG: cmd(20'h0_0555, 8'hF0);
      OP_CHIP_ERASE: cmd(20'h0_0555, 8'h10);
      OP_SWID_ENTRY: put({a[19:18], 18'h0_0555}, 16'h0090, 20'hC_07FF, 16'h00FF);
      OP_CFI_ENTRY: put({a[19:18], 18'h0_0555}, 16'h0098, 20'hC_07FF, 16'h00FF);
      OP_SUSPEND: put(a, 16'h00B0, 20'h0, 16'h00FF);
      OP_RESUME: put(a, 16'h0030, 20'h0, 16'h00FF);
      OP_EXIT_SHORT: put(a, 16'h00F0, 20'h0, 16'h00FF);
      OP_SECTOR_ERASE: put(a, 16'h0030, 20'hF_F800, 16'h00FF);
      OP_BLOCK_ERASE: put(a, 16'h0050, 20'hF_8000, 16'h00FF);
      default: ;
    endcase
    if (op inside {OP_PROGRAM, OP_SECID_PROGRAM})
      put(a, d, 20'hF_FFFF, word_mode ? 16'hFFFF : 16'h00FF);
    if (op == OP_SECID_LOCK)
      put(a, 16'h0000, 20'h0, 16'hFFFF);
  endtask

  // One request: handshake, bounded wait, then compare logged writes
  task automatic run(input op_e op, input logic [19:0] a, input logic [15:0] d);
    int n;
    logic [35:0] e;
    logic [35:0] m;
    logic [35:0] g;
    @(posedge clk);
    build(op, a, d);
    got_ref = 1'b0;
    low_rst = 1'b0;
    req_valid <= 1'b1;
    req <= '{op: op, addr: a, data: d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    if (req_ready !== 1'b1) begin
      errors++;
      test_done();
    end
    req_valid <= 1'b0;
    n = 0;
    while (done_q !== 1'b1 && !got_ref && n < 300) begin
      @(posedge clk);
      got_ref |= (refused_q === 1'b1);
      low_rst |= (frst_n === 1'b0);
      n++;
    end
    if (n >= 300) begin
      errors++;
      test_done();
    end
    // Idle gap lets any trailing pulse pass before the next request
    repeat (3) @(posedge clk);
    check(got_ref === (op == OP_SECID_LOCK && word_mode === 1'b0), "refusal");
    check(u_flash_dev_model.got.size() == exp_q.size(), "write count");
    while (exp_q.size() > 0 && u_flash_dev_model.got.size() > 0) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      g = u_flash_dev_model.got.pop_front();
      check(((g ^ e) & m) === 36'h0, "write cycle");
    end
    exp_q.delete();
    msk_q.delete();
    u_flash_dev_model.got.delete();
  endtask

  // ----
  // Clock and main sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    logic [19:0] a;
    logic [15:0] d;
    errors = 0;
    checks = 0;
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    word_mode = 1'b1;
    void'($urandom(32'h7583));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    // Every write command in word then byte mode
    for (int w = 1; w >= 0; w--) begin
      word_mode <= w[0];
      for (int k = 0; k <= 12; k++) begin
        a = 20'($urandom());
        d = 16'($urandom());
        run(op_e'(k), a, d);
      end
    end
    word_mode <= 1'b1;
    run(OP_READ, a, d);
    check(rdata_q === (a[15:0] ^ 16'h5A5A), "read data");
    run(OP_ABORT, a, d);
    check(low_rst === 1'b1, "reset pin");
    // Reset in mid-sequence, then a program must still come out whole
    req_valid <= 1'b1;
    req <= '{op: OP_SECTOR_ERASE, addr: a, data: d};
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    run(OP_PROGRAM, a, d);
    test_done();
  end
endmodule // flash_cmd_host_tb
